// ---- common/pio_pkg.sv ----
// package for the parallel i/o port: register offsets, modes, carriers
`default_nettype none
package pio_pkg;
    // register indices of the four host-visible registers
    localparam logic [1:0] PIO_OFS_DATA = 2'h0;
    localparam logic [1:0] PIO_OFS_DIR  = 2'h1;
    localparam logic [1:0] PIO_OFS_MASK = 2'h2;
    localparam logic [1:0] PIO_OFS_EDGE = 2'h3;
    // build-time direction setting
    typedef enum logic [1:0] {
        PIO_DIR_BIDIR = 2'b00,
        PIO_DIR_IN    = 2'b01,
        PIO_DIR_OUT   = 2'b10,
        PIO_DIR_INOUT = 2'b11
    } pio_dir_mode_type;
    // build-time edge selection
    typedef enum logic [1:0] {
        PIO_EDGE_RISE = 2'b00,
        PIO_EDGE_FALL = 2'b01,
        PIO_EDGE_ANY  = 2'b10
    } pio_edge_mode_type;
    // build-time interrupt source
    typedef enum logic {
        PIO_IRQ_LEVEL = 1'b0,
        PIO_IRQ_EDGE  = 1'b1
    } pio_irq_mode_type;
    // host transfer request
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [1:0]  addr;
        logic [31:0] wdata;
    } pio_req_type;
    // reset values
    localparam logic [31:0] PIO_RST_WORD = 32'h0000_0000;
    localparam logic        PIO_RST_BIT  = 1'b0;
    localparam int          PIO_MAX_PORTS = 32;
endpackage : pio_pkg
`default_nettype wire

// ---- hdl/pio_core.sv ----
// parallel i/o port core: registers, edge capture, interrupt, pin drive
`default_nettype none
module pio_core
    import pio_pkg::*;
#(
    parameter int                WIDTH     = 32,
    parameter pio_dir_mode_type  DIR_MODE  = PIO_DIR_INOUT,
    parameter bit                HAS_EDGE  = 1'b1,
    parameter pio_edge_mode_type EDGE_MODE = PIO_EDGE_RISE,
    parameter bit                HAS_IRQ   = 1'b1,
    parameter pio_irq_mode_type  IRQ_MODE  = PIO_IRQ_LEVEL
) (
    input  wire logic             i_clk,
    input  wire logic             i_sys_rst,
    input  wire logic             i_ce,
    input  wire pio_req_type      i_req,
    output var  logic [31:0]      o_rdata,
    output var  logic             o_rvalid,
    output var  logic             o_irq,
    input  wire logic [WIDTH-1:0] i_port,
    output var  logic [WIDTH-1:0] o_port,
    output var  logic [WIDTH-1:0] o_port_oe
);
    // build-time presence of each part
    localparam bit HAS_IN  = (DIR_MODE != PIO_DIR_OUT);
    localparam bit HAS_OUT = (DIR_MODE != PIO_DIR_IN);
    localparam bit HAS_DIR = (DIR_MODE == PIO_DIR_BIDIR);
    localparam bit USE_EDGE = HAS_EDGE && HAS_IN;
    localparam bit USE_IRQ  = HAS_IRQ && HAS_IN;

    // host-visible state
    logic [WIDTH-1:0] out_val;   // value to drive
    logic [WIDTH-1:0] dir;       // 1 = output
    logic [WIDTH-1:0] mask;      // interrupt enables
    logic [WIDTH-1:0] cap;       // captured edges
    logic [WIDTH-1:0] cond;      // per-port interrupt condition
    logic             cap_clr;   // write to capture register
    logic [31:0]      next_rdata;

    initial begin
        if (WIDTH < 1 || WIDTH > PIO_MAX_PORTS) begin
            $error("port width out of range");
        end
    end

    // any write to capture clears it, except bits that see an edge in the same cycle
    assign cap_clr = USE_EDGE && i_req.wr && (i_req.addr == PIO_OFS_EDGE);

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            out_val <= WIDTH'(PIO_RST_WORD);
        end else if (i_ce && HAS_OUT && i_req.wr && i_req.addr == PIO_OFS_DATA) begin
            out_val <= i_req.wdata[WIDTH-1:0];
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            dir <= WIDTH'(PIO_RST_WORD);
        end else if (i_ce && HAS_DIR && i_req.wr && i_req.addr == PIO_OFS_DIR) begin
            dir <= i_req.wdata[WIDTH-1:0];
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            mask <= WIDTH'(PIO_RST_WORD);
        end else if (i_ce && USE_IRQ && i_req.wr && i_req.addr == PIO_OFS_MASK) begin
            mask <= i_req.wdata[WIDTH-1:0];
        end
    end

    genvar g;
    generate
        if (USE_EDGE) begin : g_edge
            for (g = 0; g < WIDTH; g++) begin : g_bit
                pio_edge_det #(
                    .EDGE_MODE (EDGE_MODE)
                ) u_det (
                    .i_clk     (i_clk),
                    .i_sys_rst (i_sys_rst),
                    .i_ce      (i_ce),
                    .i_pin     (i_port[g]),
                    .i_clear   (cap_clr),
                    .o_cap     (cap[g])
                );
            end
        end else begin : g_noedge
            assign cap = '0;
        end
    endgenerate

    // interrupt condition per port
    always_comb begin
        if (IRQ_MODE == PIO_IRQ_EDGE) begin
            cond = cap;
        end else begin
            cond = i_port;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_irq <= PIO_RST_BIT;
        end else if (i_ce) begin
            o_irq <= USE_IRQ && |(cond & mask);
        end
    end

    always_comb begin
        next_rdata = PIO_RST_WORD;
        case (i_req.addr)
            PIO_OFS_DATA: if (HAS_IN)   next_rdata[WIDTH-1:0] = i_port;
            PIO_OFS_DIR:  if (HAS_DIR)  next_rdata[WIDTH-1:0] = dir;
            PIO_OFS_MASK: if (USE_IRQ)  next_rdata[WIDTH-1:0] = mask;
            PIO_OFS_EDGE: if (USE_EDGE) next_rdata[WIDTH-1:0] = cap;
            default:      next_rdata = PIO_RST_WORD;
        endcase
    end

    // read data, one cycle after the request
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_rdata  <= PIO_RST_WORD;
            o_rvalid <= PIO_RST_BIT;
        end else if (i_ce) begin
            o_rvalid <= i_req.rd;
            if (i_req.rd) begin
                o_rdata <= next_rdata;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_port    <= WIDTH'(PIO_RST_WORD);
            o_port_oe <= WIDTH'(PIO_RST_WORD);
        end else if (i_ce) begin
            o_port    <= HAS_OUT ? out_val : '0;
            o_port_oe <= HAS_DIR ? dir : (HAS_OUT ? '1 : '0);
        end
    end

    // assertions
    // capture clear with quiet pins
    cap_clear_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_ce && cap_clr && $past(i_ce) && !$past(i_sys_rst) && !$changed(i_port))
        |=> (cap == '0))
        else $error("capture not cleared");
    cap_hold_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_ce && !cap_clr) |=> ((cap & $past(cap)) == $past(cap)))
        else $error("capture bit lost");
    irq_value_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_ce |=> (o_irq == (USE_IRQ && |($past(cond) & $past(mask)))))
        else $error("irq wrong");
    data_read_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_ce && i_req.rd && i_req.addr == PIO_OFS_DATA && HAS_IN)
        |=> (o_rvalid && o_rdata[WIDTH-1:0] == $past(i_port)))
        else $error("data read wrong");
    // write reaches pins in two cycles
    out_write_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (HAS_OUT && i_ce && i_req.wr && i_req.addr == PIO_OFS_DATA) ##1 i_ce
        |=> (o_port == $past(i_req.wdata[WIDTH-1:0], 2)))
        else $error("output not updated");
    dir_release_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (HAS_DIR && i_ce) |=> (o_port_oe == $past(dir)))
        else $error("enable mismatch");
    mask_gate_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_ce && mask == '0) |=> !o_irq)
        else $error("masked irq");
    absent_read_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (!HAS_DIR && i_ce && i_req.rd && i_req.addr == PIO_OFS_DIR) |=> (o_rdata == '0))
        else $error("absent register nonzero");

    // read side checks
    // mask reads back
    mask_read_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (USE_IRQ && i_ce && i_req.rd && i_req.addr == PIO_OFS_MASK)
        |=> (o_rdata[WIDTH-1:0] == $past(mask)))
        else $error("mask read wrong");
    dir_read_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (HAS_DIR && i_ce && i_req.rd && i_req.addr == PIO_OFS_DIR)
        |=> (o_rdata[WIDTH-1:0] == $past(dir)))
        else $error("direction read wrong");
    cap_read_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (USE_EDGE && i_ce && i_req.rd && i_req.addr == PIO_OFS_EDGE)
        |=> (o_rdata[WIDTH-1:0] == $past(cap)))
        else $error("capture read wrong");
    // bits above the ports read zero
    upper_zero_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_ce && i_req.rd) |=> ((o_rdata >> WIDTH) == '0))
        else $error("upper read bits set");
    valid_pulse_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_ce && !i_req.rd) |=> (!o_rvalid && $stable(o_rdata)))
        else $error("stray read valid");

    // write side checks
    // mask write lands
    mask_write_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (USE_IRQ && i_ce && i_req.wr && i_req.addr == PIO_OFS_MASK)
        |=> (mask == $past(i_req.wdata[WIDTH-1:0])))
        else $error("mask write lost");
    dir_write_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (HAS_DIR && i_ce && i_req.wr && i_req.addr == PIO_OFS_DIR)
        |=> (dir == $past(i_req.wdata[WIDTH-1:0])))
        else $error("direction write lost");
    dir_absent_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (!HAS_DIR && i_ce) |=> (dir == '0))
        else $error("absent direction written");
    oe_fixed_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (!HAS_DIR && i_ce) |=> (o_port_oe == {WIDTH{HAS_OUT}}))
        else $error("fixed enable wrong");
    out_absent_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (!HAS_OUT && i_ce) |=> (o_port == '0))
        else $error("absent output driven");

    // interrupt source checks
    // enabled high level raises irq
    level_irq_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (USE_IRQ && IRQ_MODE == PIO_IRQ_LEVEL && i_ce && |(i_port & mask)) |=> o_irq)
        else $error("level irq missing");
    edge_irq_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (USE_IRQ && IRQ_MODE == PIO_IRQ_EDGE && i_ce && |(cap & mask)) |=> o_irq)
        else $error("edge irq missing");

    // presence checks
    // no irq without interrupt logic
    irq_absent_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (!USE_IRQ && i_ce) |=> !o_irq)
        else $error("absent irq raised");
    cap_absent_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (!USE_EDGE && i_ce) |=> (cap == '0))
        else $error("absent capture set");
    read_answer_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_ce && i_req.rd) |=> o_rvalid)
        else $error("read not answered");

    ce_freeze_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        !i_ce |=> ($stable(o_port) && $stable(o_port_oe) && $stable(o_irq)
                   && $stable(cap) && $stable(o_rdata) && $stable(o_rvalid)))
        else $error("state moved while frozen");
    // main scenarios
    irq_seen_c: cover property (@(posedge i_clk) disable iff (i_sys_rst) $rose(o_irq));
    cap_set_c:  cover property (@(posedge i_clk) disable iff (i_sys_rst) $rose(|cap));
    clear_c:    cover property (@(posedge i_clk) disable iff (i_sys_rst) cap_clr ##1 cap == '0);
    read_c:     cover property (@(posedge i_clk) disable iff (i_sys_rst) o_rvalid);
    freeze_c:   cover property (@(posedge i_clk) disable iff (i_sys_rst) !i_ce ##1 i_ce);
endmodule : pio_core
`default_nettype wire

// ---- hdl/pio_edge_det.sv ----
// edge detector for one input port with a sticky capture bit
`default_nettype none
module pio_edge_det
    import pio_pkg::*;
#(
    parameter pio_edge_mode_type EDGE_MODE = PIO_EDGE_RISE
) (
    input  wire logic i_clk,
    input  wire logic i_sys_rst,
    input  wire logic i_ce,
    input  wire logic i_pin,
    input  wire logic i_clear,
    output var  logic o_cap
);
    // previous sample of the pin
    logic prev;
    // qualifying edge this cycle
    logic hit;

    always_comb begin
        case (EDGE_MODE)
            PIO_EDGE_RISE: hit = i_pin & ~prev;
            PIO_EDGE_FALL: hit = ~i_pin & prev;
            PIO_EDGE_ANY:  hit = i_pin ^ prev;
            default:       hit = 1'b0;
        endcase
    end

    // previous sample register
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            prev <= PIO_RST_BIT;
        end else if (i_ce) begin
            prev <= i_pin;
        end
    end

    // sticky bit, set wins over clear
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_cap <= PIO_RST_BIT;
        end else if (i_ce) begin
            if (hit) begin
                o_cap <= 1'b1;
            end else if (i_clear) begin
                o_cap <= 1'b0;
            end
        end
    end
endmodule : pio_edge_det
`default_nettype wire

// ---- sim/parallel_io_port_core_tb.sv ----
// testbench for the parallel i/o port core: a bidirectional and a split-port build
`default_nettype none
module parallel_io_port_core_tb
    import pio_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int W = 8;
    logic           i_clk = 1'b0;
    logic           i_sys_rst = 1'b1;
    logic           i_ce = 1'b1;
    pio_req_type    req;
    logic [31:0]    rdata;
    logic           rvalid;
    logic           irq;
    logic [W-1:0]   ext = '0;      // far-side drive on the shared pins
    logic [W-1:0]   port;
    logic [W-1:0]   oe;
    logic [W-1:0]   pin;           // resolved pin level
    logic [31:0]    rdata2;        // split-port build: read data
    logic           irq2;          // split-port build: interrupt
    logic [W-1:0]   port2;         // split-port build: output value
    logic [W-1:0]   oe2;           // split-port build: enables
    int             fails = 0;
    int             samples_checked = 0;
    // clock of 40 ns
    always #20 i_clk = ~i_clk;
    // driver wins where enabled, far side elsewhere
    assign pin = (oe & port) | (~oe & ext);
    pio_host HOST (.i_clk(i_clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_req(req));
    pio_core #(.WIDTH(W), .DIR_MODE(PIO_DIR_BIDIR), .HAS_EDGE(1'b1), .EDGE_MODE(PIO_EDGE_RISE),
               .HAS_IRQ(1'b1), .IRQ_MODE(PIO_IRQ_LEVEL)) DUT (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_req(req), .o_rdata(rdata),
        .o_rvalid(rvalid), .o_irq(irq), .i_port(pin), .o_port(port), .o_port_oe(oe));
    // split ports, either-edge capture, edge irq; shares the host requests
    pio_core #(.WIDTH(W), .DIR_MODE(PIO_DIR_INOUT), .HAS_EDGE(1'b1), .EDGE_MODE(PIO_EDGE_ANY),
               .HAS_IRQ(1'b1), .IRQ_MODE(PIO_IRQ_EDGE)) DUT2 (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_req(req), .o_rdata(rdata2),
        .o_rvalid(), .o_irq(irq2), .i_port(ext), .o_port(port2), .o_port_oe(oe2));
    task automatic cyc(input int n);
        repeat (n) @(negedge i_clk);
    endtask : cyc
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic rchk(input string nm, input logic [1:0] a, input logic [31:0] e);
        logic [31:0] d;
        bit ok;
        HOST.rd(a, d, ok);
        if (!ok) begin
            fails++;
            $display("wrong value %s expected valid seen none", nm);
            end_sim();
        end else begin
            chk(nm, e, d);
        end
    endtask : rchk
    task automatic t_reset();
        chk("oe", 32'h0000_0000, {24'h0, oe});
        chk("irq", 32'h0000_0000, {31'h0, irq});
        chk("oe2", 32'h0000_00ff, {24'h0, oe2});
        rchk("dir", PIO_OFS_DIR, 32'h0000_0000);
        rchk("mask", PIO_OFS_MASK, 32'h0000_0000);
        rchk("cap", PIO_OFS_EDGE, 32'h0000_0000);
        $display("reset test done");
    endtask : t_reset
    task automatic t_data();
        HOST.wr(PIO_OFS_DATA, 32'h0000_00a5);
        ext = 8'h3c;
        cyc(2);
        chk("port", 32'h0000_00a5, {24'h0, port});
        chk("port2", 32'h0000_00a5, {24'h0, port2});
        rchk("data", PIO_OFS_DATA, 32'h0000_003c);
        $display("data test done");
    endtask : t_data
    task automatic t_dir();
        HOST.wr(PIO_OFS_DIR, 32'h0000_000f);
        cyc(2);
        chk("oe", 32'h0000_000f, {24'h0, oe});
        chk("oe2", 32'h0000_00ff, {24'h0, oe2});
        rchk("data", PIO_OFS_DATA, 32'h0000_0035);
        rchk("dir", PIO_OFS_DIR, 32'h0000_000f);
        chk("dir2", 32'h0000_0000, rdata2);
        HOST.wr(PIO_OFS_DIR, 32'h0000_0000);
        $display("direction test done");
    endtask : t_dir
    task automatic t_edge();
        ext = 8'h00;
        cyc(3);
        HOST.wr(PIO_OFS_EDGE, 32'hffff_ffff);
        cyc(2);
        rchk("cap", PIO_OFS_EDGE, 32'h0000_0000);
        ext = 8'h81;
        cyc(3);
        rchk("cap", PIO_OFS_EDGE, 32'h0000_0081);
        ext = 8'h00;
        cyc(3);
        rchk("cap", PIO_OFS_EDGE, 32'h0000_0081);
        HOST.wr(PIO_OFS_EDGE, 32'h0000_0000);
        cyc(2);
        rchk("cap", PIO_OFS_EDGE, 32'h0000_0000);
        $display("edge test done");
    endtask : t_edge
    task automatic t_irq();
        int n;
        HOST.wr(PIO_OFS_MASK, 32'h0000_0002);
        ext = 8'h01;
        cyc(3);
        chk("irq", 32'h0000_0000, {31'h0, irq});
        chk("irq2", 32'h0000_0000, {31'h0, irq2});
        ext = 8'h03;
        for (n = 0; n < 4 && irq !== 1'b1; n++) cyc(1);
        if (irq !== 1'b1) begin
            fails++;
            $display("wrong value irq expected 1 seen %b", irq);
            end_sim();
        end else begin
            chk("irq", 32'h0000_0001, {31'h0, irq});
        end
        cyc(1);
        chk("irq2", 32'h0000_0001, {31'h0, irq2});
        rchk("mask", PIO_OFS_MASK, 32'h0000_0002);
        ext = 8'h00;
        cyc(3);
        chk("irq", 32'h0000_0000, {31'h0, irq});
        chk("irq2", 32'h0000_0001, {31'h0, irq2});
        HOST.wr(PIO_OFS_EDGE, 32'h0000_0000);
        cyc(3);
        chk("irq2", 32'h0000_0000, {31'h0, irq2});
        HOST.wr(PIO_OFS_MASK, 32'h0000_0000);
        cyc(3);
        chk("irq", 32'h0000_0000, {31'h0, irq});
        $display("interrupt test done");
    endtask : t_irq
    task automatic t_ce();
        i_ce = 1'b0;
        HOST.wr(PIO_OFS_DATA, 32'h0000_005a);
        cyc(2);
        chk("port", 32'h0000_00a5, {24'h0, port});
        i_ce = 1'b1;
        cyc(2);
        chk("port2", 32'h0000_00a5, {24'h0, port2});
        $display("clock enable test done");
    endtask : t_ce
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim
    // reset for six cycles, then the scenarios
    initial begin
        cyc(6);
        i_sys_rst = 1'b0;
        cyc(1);
        t_reset();
        t_data();
        t_dir();
        t_edge();
        t_irq();
        t_ce();
        end_sim();
    end
endmodule : parallel_io_port_core_tb
`default_nettype wire

// ---- sim/pio_host.sv ----
// host model: single read and write transfers on the register port
`default_nettype none
module pio_host
    import pio_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic [31:0] i_rdata,
    input  wire logic        i_rvalid,
    output var  pio_req_type o_req
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle bus from time zero
    initial o_req = '{rd: 1'b0, wr: 1'b0, addr: 2'h0, wdata: 32'h0000_0000};
    task automatic wr(input logic [1:0] a, input logic [31:0] d);
        @(negedge i_clk);
        o_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(negedge i_clk);
        // released lines stop showing the old value
        o_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    endtask : wr
    // one-cycle read, bounded wait for valid
    task automatic rd(input logic [1:0] a, output logic [31:0] d, output bit ok);
        int n;
        ok = 1'b0;
        d  = 32'h0000_0000;
        @(negedge i_clk);
        o_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 32'hdead_beef};
        @(negedge i_clk);
        o_req.rd = 1'b0;
        for (n = 0; n < 4 && !ok; n++) begin
            // take the data in the valid cycle
            if (i_rvalid === 1'b1) begin
                ok = 1'b1;
                d  = i_rdata;
            end else begin
                @(negedge i_clk);
            end
        end
    endtask : rd
endmodule : pio_host
`default_nettype wire
